// [hdl/lfc_adv.sv]
`timescale 1ns/1ps
module lfc_adv
  import lfc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clr,
  input  wire logic       start,
  input  wire logic [2:0] count,
  input  wire logic       cmd_ready,
  output logic            cmd_valid,
  output logic      [2:0] letter,
  output logic            sent_any,
  output logic            busy
);
  logic [2:0] left;

  // one credit command per local credit, letters from A upward
  assign cmd_valid = left != 3'h0;
  assign busy      = cmd_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      left     <= 3'h0;
      letter   <= LETTER_A;
      sent_any <= 1'b0;
    end else if (start) begin
      left     <= count;
      letter   <= LETTER_A;
    end else if (cmd_valid && cmd_ready) begin
      left     <= left - 3'h1;
      letter   <= letter + 3'h1;
      sent_any <= 1'b1;
    end
  end
endmodule

// [hdl/lfc_init.sv]
`timescale 1ns/1ps
module lfc_init
  import lfc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        u0_entry,
  input  wire lfc_src_t    u0_src,
  input  wire logic [3:0]  rx_seq,
  input  wire logic        lbad_sent_before,
  input  wire logic        lbad_rcvd_before,
  output logic             lgood_valid,
  output logic      [3:0]  lgood_seq,
  input  wire logic        lgood_ready,
  input  wire logic        adv_rx_valid,
  input  wire logic [3:0]  adv_rx_seq,
  input  wire logic        rx_drain_done,
  input  wire logic [2:0]  free_t1,
  input  wire logic [2:0]  free_t2,
  output logic             lcrd_valid,
  output logic             lcrd_class,
  output logic      [2:0]  lcrd_letter,
  input  wire logic        lcrd_ready,
  input  wire logic        crd_rx_valid,
  input  wire logic        crd_rx_class,
  input  wire logic [2:0]  crd_rx_letter,
  input  wire logic        pkt_sent,
  input  wire logic        pkt_class,
  input  wire logic        recov_to_reset_lb,
  output logic             rx_process_enable,
  output logic             hp_tx_allow,
  output logic             t1_tx_allow,
  output logic             t2_tx_allow,
  output logic             lp_allow,
  output logic             flush_valid,
  output logic             flush_all,
  output logic      [3:0]  flush_keep_above,
  output logic      [3:0]  ack_tx_seq,
  output logic             skip_lrty_expect,
  output logic             skip_lrty_send,
  output logic             crd_order_err
);
  lfc_state_t state;
  lfc_state_t next_state;
  logic [2:0] ctrl;
  logic       dual;
  logic       wide;
  lfc_src_t   src;
  logic       seq_sent;
  logic       adv_rcvd;
  logic [3:0] adv_seq;
  logic [2:0] loc1;
  logic [2:0] loc2;
  logic [2:0] rem1;
  logic [2:0] rem2;
  logic       sent1;
  logic       sent2;
  logic       got1;
  logic       got2;
  logic       busy1;
  logic       busy2;
  logic       v1;
  logic       v2;
  logic [2:0] let1;
  logic [2:0] let2;
  logic       err1;
  logic       err2;
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // register bus decode and ready signals
  wire        aw_take  = awvalid && awready;
  wire        w_take   = wvalid && wready;
  wire        ar_take  = arvalid && arready;
  wire        do_write = aw_held && w_held && !bvalid;
  wire        ctrl_hit = aw_addr == CTRL_OFF;
  wire        wr_known = ctrl_hit || aw_addr == STAT_OFF ||
                         aw_addr == CRED_OFF || aw_addr == SEQ_OFF;
  wire        rd_known = araddr == CTRL_OFF || araddr == STAT_OFF ||
                         araddr == CRED_OFF || araddr == SEQ_OFF;

  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;

  // status words built from live block state
  wire [31:0] stat_word = {23'h0, skip_lrty_send, skip_lrty_expect,
                           lp_allow, got2, got1, sent2, sent1,
                           adv_rcvd, seq_sent};
  wire [31:0] cred_word = {17'h0, loc2, 1'b0, loc1, 1'b0, rem2,
                           1'b0, rem1};
  wire [31:0] seq_word  = {24'h0, adv_seq, ack_tx_seq};
  wire [31:0] rd_mux    = (araddr == CTRL_OFF) ? {29'h0, ctrl} :
                          (araddr == STAT_OFF) ? stat_word :
                          (araddr == CRED_OFF) ? cred_word :
                          (araddr == SEQ_OFF)  ? seq_word  : 32'h0;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response and control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
      ctrl   <= CTRL_RESET;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      if (ctrl_hit && w_strb[0])
        ctrl <= w_data[2:0];
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel, one cycle to answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // initialisation sequence, entry mode and credit limits
  wire        from_rec  = src == SRC_RECOVERY;
  wire [2:0]  max_crd   = (dual && wide) ? MAX_WIDE : MAX_NARROW;
  wire        adv_first = adv_rx_valid && !adv_rcvd && state != ST_IDLE;
  wire        drain_ok  = !from_rec || rx_drain_done;
  wire        crd_start = state == ST_DRAIN && drain_ok;
  wire [2:0]  free1_cap = (free_t1 > max_crd) ? max_crd : free_t1;
  wire [2:0]  free2_cap = (free_t2 > max_crd) ? max_crd : free_t2;
  wire [2:0]  next_loc1 = from_rec ? free1_cap : INIT_CREDITS;
  wire [2:0]  next_loc2 = from_rec ? free2_cap : INIT_CREDITS;

  // state order: LGOOD_n first, drain, then credits
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  next_state = ST_IDLE;
      ST_SEQ:   if (lgood_ready) next_state = ST_DRAIN;
      ST_DRAIN: if (drain_ok) next_state = ST_CRED;
      ST_CRED:  if (!busy1 && !busy2) next_state = ST_DONE;
      ST_DONE:  next_state = ST_DONE;
      default:  next_state = ST_IDLE;
    endcase
    if (u0_entry)
      next_state = ST_SEQ;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // latch entry conditions and sequence advert value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src       <= SRC_POLLING;
      dual      <= 1'b0;
      wide      <= 1'b0;
      lgood_seq <= 4'h0;
      seq_sent  <= 1'b0;
      skip_lrty_expect <= 1'b0;
      skip_lrty_send   <= 1'b0;
    end else if (u0_entry) begin
      src       <= u0_src;
      dual      <= ctrl[CTRL_DUAL_BIT];
      wide      <= ctrl[CTRL_WIDE_BIT];
      lgood_seq <= lfc_seq_wrap(rx_seq - SEQ_ONE,
                                ctrl[CTRL_DUAL_BIT]);
      seq_sent  <= 1'b0;
      skip_lrty_expect <= u0_src == SRC_RECOVERY
                          && lbad_sent_before;
      skip_lrty_send   <= u0_src == SRC_RECOVERY
                          && lbad_rcvd_before;
    end else if (state == ST_SEQ && lgood_ready) begin
      seq_sent  <= 1'b1;
    end
  end

  assign lgood_valid = state == ST_SEQ;

  // peer advert: flush buffers and seed ack sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_rcvd         <= 1'b0;
      adv_seq          <= 4'h0;
      ack_tx_seq       <= 4'h0;
      flush_valid      <= 1'b0;
      flush_all        <= 1'b0;
      flush_keep_above <= 4'h0;
    end else begin
      flush_valid <= adv_first && !u0_entry;
      if (u0_entry) begin
        adv_rcvd <= 1'b0;
      end else if (adv_first) begin
        adv_rcvd         <= 1'b1;
        adv_seq          <= adv_rx_seq;
        ack_tx_seq       <= lfc_seq_wrap(adv_rx_seq + SEQ_ONE,
                                         dual);
        flush_all        <= !from_rec;
        flush_keep_above <= adv_rx_seq;
      end
    end
  end

  // local credit counts taken after draining
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc1 <= 3'h0;
      loc2 <= 3'h0;
    end else if (crd_start) begin
      loc1 <= next_loc1;
      loc2 <= dual ? next_loc2 : 3'h0;
    end
  end

  // credit advertisers, class 1 also serves single class mode
  lfc_adv u_adv1 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clr       (u0_entry),
    .start     (crd_start),
    .count     (next_loc1),
    .cmd_ready (lcrd_ready),
    .cmd_valid (v1),
    .letter    (let1),
    .sent_any  (sent1),
    .busy      (busy1)
  );

  lfc_adv u_adv2 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clr       (u0_entry),
    .start     (crd_start && dual),
    .count     (next_loc2),
    .cmd_ready (lcrd_ready && !v1),
    .cmd_valid (v2),
    .letter    (let2),
    .sent_any  (sent2),
    .busy      (busy2)
  );

  // class 1 takes the single command slot first
  assign lcrd_valid  = v1 || v2;
  assign lcrd_class  = !v1 && v2;
  assign lcrd_letter = v1 ? let1 : let2;

  // remote credit counters cleared on each entry
  lfc_rcred u_rem1 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clr        (u0_entry),
    .max        (max_crd),
    .crd_valid  (crd_rx_valid && !crd_rx_class),
    .crd_letter (crd_rx_letter),
    .consume    (pkt_sent && !pkt_class),
    .count      (rem1),
    .got_any    (got1),
    .order_err  (err1)
  );

  lfc_rcred u_rem2 (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clr        (u0_entry),
    .max        (max_crd),
    .crd_valid  (crd_rx_valid && crd_rx_class && dual),
    .crd_letter (crd_rx_letter),
    .consume    (pkt_sent && pkt_class && dual),
    .count      (rem2),
    .got_any    (got2),
    .order_err  (err2)
  );

  assign crd_order_err = err1 || err2;

  // transmit gating on advert and remote credits
  wire run = state != ST_IDLE && !u0_entry;
  assign hp_tx_allow = run && !dual && adv_rcvd
                       && rem1 != 3'h0;
  assign t1_tx_allow = run && dual && adv_rcvd
                       && rem1 != 3'h0;
  assign t2_tx_allow = run && dual && adv_rcvd
                       && rem2 != 3'h0;

  // low-power entry only once both adverts are complete
  wire seq_done = seq_sent && adv_rcvd;
  wire crd_one  = sent1 && got1;
  wire crd_two  = crd_one && sent2 && got2;
  assign lp_allow = run && seq_done && (dual ? crd_two : crd_one);

  // optional continued processing on way to hot reset or loopback
  assign rx_process_enable = !recov_to_reset_lb
                             || ctrl[CTRL_KEEP_BIT];
endmodule

// [hdl/lfc_pkg.sv]
package lfc_pkg;
  // register map, byte addresses
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam logic [3:0] CRED_OFF = 4'h8;
  localparam logic [3:0] SEQ_OFF  = 4'hC;
  // control fields
  localparam int         CTRL_DUAL_BIT = 0;
  localparam int         CTRL_WIDE_BIT = 1;
  localparam int         CTRL_KEEP_BIT = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h0;
  // credit figures
  localparam logic [2:0] INIT_CREDITS = 3'h4;
  localparam logic [2:0] MAX_NARROW   = 3'h4;
  localparam logic [2:0] MAX_WIDE     = 3'h7;
  localparam logic [2:0] LETTER_A     = 3'h0;
  // sequence number wrap masks
  localparam logic [3:0] SEQ_MASK_ONE = 4'h7;
  localparam logic [3:0] SEQ_MASK_TWO = 4'hF;
  localparam logic [3:0] SEQ_ONE      = 4'h1;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_POLLING,
    SRC_HOT_RESET,
    SRC_RECOVERY
  } lfc_src_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEQ,
    ST_DRAIN,
    ST_CRED,
    ST_DONE
  } lfc_state_t;

  // sequence arithmetic wraps modulo 8 or 16
  function automatic logic [3:0] lfc_seq_wrap(input logic [3:0] v,
                                              input logic       dual);
    lfc_seq_wrap = v & (dual ? SEQ_MASK_TWO : SEQ_MASK_ONE);
  endfunction
endpackage

// [hdl/lfc_rcred.sv]
`timescale 1ns/1ps
module lfc_rcred
  import lfc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clr,
  input  wire logic [2:0] max,
  input  wire logic       crd_valid,
  input  wire logic [2:0] crd_letter,
  input  wire logic       consume,
  output logic      [2:0] count,
  output logic            got_any,
  output logic            order_err
);
  logic [2:0] expect_letter;
  wire        in_order = crd_letter == expect_letter;
  wire        inc      = crd_valid && in_order && count != max;
  wire        dec      = consume && count != 3'h0;
  wire  [2:0] next_exp = (expect_letter + 3'h1 == max) ? LETTER_A
                                                       : expect_letter + 3'h1;

  // remote credit count, saturating at the lane maximum
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      count         <= 3'h0;
      expect_letter <= LETTER_A;
      got_any       <= 1'b0;
      order_err     <= 1'b0;
    end else begin
      order_err <= crd_valid && !in_order;
      if (crd_valid && in_order) begin
        expect_letter <= next_exp;
        got_any       <= 1'b1;
      end
      if (inc && !dec)
        count <= count + 3'h1;
      else if (dec && !inc)
        count <= count - 3'h1;
    end
  end
endmodule

// [testbench/lfc_init_sva.sv]
`timescale 1ns/1ps
module lfc_init_sva
  import lfc_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       u0_entry,
  input wire lfc_src_t   u0_src,
  input wire logic [3:0] rx_seq,
  input wire logic       lbad_sent_before,
  input wire logic       lbad_rcvd_before,
  input wire logic       lgood_valid,
  input wire logic [3:0] lgood_seq,
  input wire logic       lgood_ready,
  input wire logic [3:0] adv_rx_seq,
  input wire logic       lcrd_valid,
  input wire logic       lcrd_class,
  input wire logic [2:0] lcrd_letter,
  input wire logic       lcrd_ready,
  input wire logic       hp_tx_allow,
  input wire logic       t1_tx_allow,
  input wire logic       t2_tx_allow,
  input wire logic       lp_allow,
  input wire logic       flush_valid,
  input wire logic       flush_all,
  input wire logic [3:0] flush_keep_above,
  input wire logic [3:0] ack_tx_seq,
  input wire logic       skip_lrty_expect,
  input wire logic       skip_lrty_send
);
  logic       rec;
  logic       sent;
  logic       adv;
  logic [2:0] e1;
  logic [2:0] e2;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // entry source, own advert sent, peer advert seen, next letters
  always_ff @(posedge aclk) begin
    if (!aresetn || u0_entry) begin
      rec  <= u0_src == SRC_RECOVERY;
      sent <= 1'b0;
      adv  <= 1'b0;
      e1   <= 3'h0;
      e2   <= 3'h0;
    end else begin
      if (lgood_valid && lgood_ready) sent <= 1'b1;
      if (flush_valid) adv <= 1'b1;
      if (lcrd_valid && lcrd_ready && !lcrd_class) e1 <= e1 + 3'h1;
      if (lcrd_valid && lcrd_ready && lcrd_class) e2 <= e2 + 3'h1;
    end
  end

  AST_LGOOD_SEQ: assert property (
    u0_entry |=> lgood_valid && lgood_seq[2:0] == $past(rx_seq[2:0]) - 3'h1)
    else $error("advertised sequence wrong");
  AST_ACK_SEQ: assert property (
    flush_valid |-> ack_tx_seq[2:0] == $past(adv_rx_seq[2:0]) + 3'h1)
    else $error("ack sequence wrong");
  AST_FLUSH_ALL: assert property (flush_valid && !rec |-> flush_all)
    else $error("flush not total");
  AST_FLUSH_KEEP: assert property (
    flush_valid && rec |-> !flush_all &&
    flush_keep_above[2:0] == $past(adv_rx_seq[2:0]))
    else $error("flush limit wrong");
  AST_ENTRY_CLEAR: assert property (
    u0_entry |=> !(hp_tx_allow || t1_tx_allow || t2_tx_allow || lp_allow))
    else $error("allow left over");
  AST_SEND_GATE: assert property (
    hp_tx_allow || t1_tx_allow || t2_tx_allow |-> adv || flush_valid)
    else $error("send before advert");
  AST_LP_GATE: assert property (
    lp_allow |-> sent && (adv || flush_valid))
    else $error("low power too early");
  AST_CRED_AFTER: assert property (lcrd_valid |-> sent)
    else $error("credit before lgood");
  AST_LCRD_HOLD: assert property (
    lcrd_valid && !lcrd_ready |=> lcrd_valid && $stable(lcrd_letter) &&
    $stable(lcrd_class))
    else $error("credit dropped");
  AST_LETTER: assert property (
    lcrd_valid |-> lcrd_letter == (lcrd_class ? e2 : e1))
    else $error("credit letter wrong");
  AST_SKIP: assert property (
    u0_entry && u0_src == SRC_RECOVERY |=>
    skip_lrty_expect == $past(lbad_sent_before) &&
    skip_lrty_send == $past(lbad_rcvd_before))
    else $error("lrty skip wrong");

  // main scenarios
  COV_REC: cover property (flush_valid && rec);
  COV_CLASS2: cover property (lcrd_valid && lcrd_class);
  COV_LP: cover property (lp_allow);
endmodule

// [testbench/lfc_peer.sv]
`timescale 1ns/1ps
module lfc_peer
  import lfc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       u0_entry,
  input  wire logic       slow,
  input  wire logic [3:0] adv_seq,
  input  wire logic [2:0] give1,
  input  wire logic [2:0] give2,
  input  wire logic       lgood_valid,
  input  wire logic       lcrd_valid,
  input  wire logic       lcrd_class,
  input  wire logic [2:0] lcrd_letter,
  output logic            lgood_ready,
  output logic            lcrd_ready,
  output logic            adv_rx_valid,
  output logic      [3:0] adv_rx_seq,
  output logic            crd_rx_valid,
  output logic            crd_rx_class,
  output logic      [2:0] crd_rx_letter,
  output logic      [2:0] n1,
  output logic      [2:0] n2,
  output logic            bad
);
  logic       go;
  logic       told;
  logic [2:0] k1;
  logic [2:0] k2;

  // answers handshakes, advertises, hands out credits, logs ours
  always @(posedge aclk) begin
    if (!aresetn) begin
      {lgood_ready, lcrd_ready, adv_rx_valid, crd_rx_valid} <= 4'h0;
      {adv_rx_seq, crd_rx_class, crd_rx_letter} <= 8'h00;
      {go, told, k1, k2, n1, n2, bad} <= 15'h0000;
    end else begin
      lgood_ready   <= slow ? ~lgood_ready : 1'b1;
      lcrd_ready    <= slow ? ~lcrd_ready : 1'b1;
      adv_rx_valid  <= 1'b0;
      crd_rx_valid  <= 1'b0;
      adv_rx_seq    <= ~adv_rx_seq;    // released lines churn
      crd_rx_letter <= ~crd_rx_letter;
      crd_rx_class  <= ~crd_rx_class;
      if (u0_entry) begin
        {go, told, k1, k2, n1, n2, bad} <= 15'h0000;
      end else begin
        if (lgood_valid && lgood_ready) go <= 1'b1;
        if (go && !told) begin
          told         <= 1'b1;
          adv_rx_valid <= 1'b1;
          adv_rx_seq   <= adv_seq;
        end else if (told && k1 != give1) begin
          crd_rx_valid  <= 1'b1;
          crd_rx_class  <= 1'b0;
          crd_rx_letter <= k1;
          k1            <= k1 + 3'h1;
        end else if (told && k2 != give2) begin
          crd_rx_valid  <= 1'b1;
          crd_rx_class  <= 1'b1;
          crd_rx_letter <= k2;
          k2            <= k2 + 3'h1;
        end
        if (lcrd_valid && lcrd_ready) begin
          if (lcrd_letter != (lcrd_class ? n2 : n1)) bad <= 1'b1;
          if (lcrd_class) n2 <= n2 + 3'h1;
          else n1 <= n1 + 3'h1;
        end
      end
    end
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb
  import lfc_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, u0_entry, lbad_sent_before;
  logic lbad_rcvd_before, lgood_valid, lgood_ready, adv_rx_valid;
  logic rx_drain_done, lcrd_valid, lcrd_class, lcrd_ready, crd_rx_valid;
  logic crd_rx_class, pkt_sent, pkt_class, recov_to_reset_lb;
  logic rx_process_enable, hp_tx_allow, t1_tx_allow, t2_tx_allow, lp_allow;
  logic flush_valid, flush_all, skip_lrty_expect, skip_lrty_send;
  logic crd_order_err, slow, bad;
  logic [3:0]  awaddr, araddr, wstrb, rx_seq, lgood_seq, adv_rx_seq;
  logic [3:0]  flush_keep_above, ack_tx_seq, adv_seq;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  free_t1, free_t2, lcrd_letter, crd_rx_letter;
  logic [2:0]  give1, give2, n1, n2;
  lfc_src_t    u0_src;
  int          mismatches, checks_done;

  assign wstrb = 4'hF;
  lfc_init i_lfc_init (.*);
  lfc_peer i_lfc_peer (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  task automatic await(ref logic s, input string m);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    chk(s === 1'b1, m);
  endtask

  task automatic link_up(input lfc_src_t s, input logic [3:0] rs, m);
    @(posedge aclk);
    u0_entry <= 1'b1;
    u0_src   <= s;
    rx_seq   <= rs;
    @(posedge aclk);
    u0_entry <= 1'b0;
    await(lgood_valid, "no lgood");
    chk(lgood_seq === ((rs - 4'h1) & m), "lgood seq");
    chk(hp_tx_allow === 1'b0 && t1_tx_allow === 1'b0, "early send");
    await(flush_valid, "no flush");
  endtask

  task automatic settle;
    int n;
    await(lp_allow, "no lp allow");
    n = 0;
    while (lcrd_valid !== 1'b0 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(lcrd_valid === 1'b0, "credits stuck");
  endtask

  task automatic pkt(input logic c);
    @(posedge aclk);
    {pkt_sent, pkt_class} <= {1'b1, c};
    @(posedge aclk);
    pkt_sent <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic sc_regs;
    logic [31:0] d;
    logic [1:0]  r;
    recov_to_reset_lb <= 1'b1;
    rd(CTRL_OFF, d, r);
    chk(d === 32'h0 && r === RESP_OKAY, "ctrl reset");
    wr(CTRL_OFF, 32'h4, r);
    chk(rx_process_enable === 1'b1 && r === RESP_OKAY, "keep on");
    wr(CTRL_OFF, 32'h0, r);
    chk(rx_process_enable === 1'b0, "keep off");
    recov_to_reset_lb <= 1'b0;
    wr(STAT_OFF, 32'h1FF, r);
    rd(STAT_OFF, d, r);
    chk(d === 32'h0 && r === RESP_OKAY, "status read only");
    rd(4'h2, d, r);
    chk(r === RESP_SLVERR && d === 32'h0, "unmapped");
    wr(4'h2, 32'h0, r);
    chk(r === RESP_SLVERR, "unmapped write");
  endtask

  task automatic sc_poll;
    logic [1:0] r;
    wr(CTRL_OFF, 32'h0, r);
    {give1, give2, adv_seq, slow} <= {3'h2, 3'h0, 4'h7, 1'b0};
    link_up(SRC_POLLING, 4'h0, 4'h7);
    chk(flush_all === 1'b1, "flush all");
    chk(ack_tx_seq === 4'h0, "ack wrap");
    settle;
    chk(n1 === 3'h4 && bad === 1'b0, "four credits");
    chk(hp_tx_allow === 1'b1, "hp allow");
    pkt(1'b0);
    chk(hp_tx_allow === 1'b1, "hp one left");
    pkt(1'b0);
    chk(hp_tx_allow === 1'b0, "hp at zero");
  endtask

  task automatic sc_rec;
    {give1, adv_seq, slow, free_t1} <= {3'h1, 4'h1, 1'b1, 3'h2};
    {rx_drain_done, lbad_sent_before, lbad_rcvd_before} <= 3'h2;
    link_up(SRC_RECOVERY, 4'h3, 4'h7);
    chk(flush_all === 1'b0 && flush_keep_above === 4'h1, "keep");
    chk(ack_tx_seq === 4'h2, "ack seq");
    chk(skip_lrty_expect === 1'b1 && skip_lrty_send === 1'b0, "lrty");
    repeat (10) begin
      @(posedge aclk);
      chk(lcrd_valid === 1'b0, "credit before drain");
    end
    rx_drain_done <= 1'b1;
    settle;
    chk(n1 === 3'h2 && bad === 1'b0, "free credits");
    {lbad_sent_before, lbad_rcvd_before} <= 2'h1;
    link_up(SRC_RECOVERY, 4'h0, 4'h7);
    chk(skip_lrty_expect === 1'b0 && skip_lrty_send === 1'b1, "lrty");
    settle;
  endtask

  task automatic sc_dual;
    logic [31:0] d;
    logic [1:0]  r;
    wr(CTRL_OFF, 32'h3, r);
    {give1, give2, adv_seq, slow} <= {3'h7, 3'h1, 4'h9, 1'b0};
    {free_t1, free_t2, lbad_rcvd_before} <= {3'h7, 3'h5, 1'b0};
    link_up(SRC_RECOVERY, 4'h0, 4'hF);
    chk(flush_keep_above === 4'h9 && ack_tx_seq === 4'hA, "seq16");
    settle;
    chk(n1 === 3'h7 && n2 === 3'h5 && bad === 1'b0, "seven");
    rd(CRED_OFF, d, r);
    chk(d[2:0] === 3'h7 && d[6:4] === 3'h1, "remote counts");
    chk(t1_tx_allow === 1'b1 && t2_tx_allow === 1'b1, "typed");
    pkt(1'b1);
    chk(t2_tx_allow === 1'b0 && t1_tx_allow === 1'b1, "class");
  endtask

  task automatic sc_order;
    logic [31:0] d;
    logic [1:0]  r;
    wr(CTRL_OFF, 32'h1, r);
    {give1, give2, adv_seq} <= {3'h5, 3'h1, 4'h3};
    link_up(SRC_POLLING, 4'h5, 4'hF);
    chk(ack_tx_seq === 4'h4 && flush_all === 1'b1, "dual ack");
    await(crd_order_err, "no order error");
    settle;
    rd(CRED_OFF, d, r);
    chk(d[2:0] === 3'h4 && d[6:4] === 3'h1, "narrow cap");
    chk(n1 === 3'h4 && n2 === 3'h4 && bad === 1'b0, "dual four");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    complete_run;
  end

  // reset, then the scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, rx_seq, adv_seq} = 48'h0;
    {u0_entry, lbad_sent_before, lbad_rcvd_before, rx_drain_done} = 4'h1;
    {pkt_sent, pkt_class, recov_to_reset_lb, slow} = 4'h0;
    {free_t1, free_t2, give1, give2} = 12'h000;
    u0_src = SRC_POLLING;
    {mismatches, checks_done} = {32'h0, 32'h0};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    sc_regs;
    sc_poll;
    sc_rec;
    sc_dual;
    sc_order;
    complete_run;
  end
endmodule

bind lfc_init lfc_init_sva i_lfc_init_sva (.*);
